// ---- hw/clkgen_pkg.sv ----
// constants for the clock generator trim and status block
package clkgen_pkg;
  // byte offsets on the register bus
  localparam logic [3:0] OFS_TRIM   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  // status register field positions
  localparam int LOST_BIT  = 7;
  localparam int LOCK_BIT  = 6;
  localparam int LOOPS_BIT = 5;
  localparam int REFS_BIT  = 4;
  localparam int MODE_LSB  = 2;
  localparam int OSC_BIT   = 1;
  localparam int FINE_BIT  = 0;
  // control register field positions
  localparam int CS_LSB    = 0;
  localparam int REFSEL    = 2;
  localparam int LOOPSEL   = 3;
  localparam int REFDIV_LSB = 4;
  localparam int VCODIV_LSB = 8;
  localparam int OSCREQ    = 12;
  localparam int EXTEN     = 13;
  localparam int IRQEN     = 14;
  localparam int LOWPWR    = 15;
  localparam int CTRL_W    = 16;
  // reset values
  localparam logic [7:0]        TRIM_RESET = 8'h80;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0104;
  // clock mode codes (select and status)
  localparam logic [1:0] MODE_LOOP = 2'h0;
  localparam logic [1:0] MODE_INT  = 2'h1;
  localparam logic [1:0] MODE_EXT  = 2'h2;
  localparam logic [1:0] MODE_PLL  = 2'h3;
  // stages of the status crossing
  localparam int SYNC_STAGES = 2;
endpackage : clkgen_pkg

// ---- hw/status_sync.sv ----
// per-bit two-stage synchroniser for status fields
`timescale 1ns/1ps
`default_nettype none
module status_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_level,
  input  wire logic [WIDTH-1:0] i_reset_val,
  output logic      [WIDTH-1:0] o_level
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic sync_reg;
      logic sync_next;
      // first stage read only by the second
      always_comb begin
        meta_next = i_level[g];
        sync_next = meta_reg;
      end
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          meta_reg <= i_reset_val[g];
          sync_reg <= i_reset_val[g];
        end else begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
        end
      end
      assign o_level[g] = sync_reg;
    end
  endgenerate
endmodule : status_sync
`default_nettype wire

// ---- hw/lock_tracker.sv ----
// lock indication with hold-off until relock
`timescale 1ns/1ps
`default_nettype none
module lock_tracker (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_detect_en,
  input  wire logic i_raw_lock,
  input  wire logic i_disturb,
  input  wire logic i_drift_out,
  output logic      o_lock,
  output logic      o_lost_event
);
  logic lock_reg, lock_next;
  logic hold_reg, hold_next;
  logic lost_reg, lost_next;

  // hold stays until the loop itself drops lock, so a stale lock never counts
  always_comb begin
    hold_next = hold_reg;
    if (i_disturb || !i_detect_en) hold_next = 1'b1;
    else if (!i_raw_lock) hold_next = 1'b0;
    lost_next = i_detect_en && lock_reg && i_drift_out;
    lock_next = i_detect_en && i_raw_lock && !hold_next && !i_disturb && !i_drift_out;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lock_reg <= 1'b0;
      hold_reg <= 1'b1;
      lost_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      hold_reg <= hold_next;
      lost_reg <= lost_next;
    end
  end
  assign o_lock       = lock_reg;
  assign o_lost_event = lost_reg;

  a_lock_disturb: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_disturb |=> !o_lock ##1 (!o_lock || !$past(i_raw_lock) || !$past(hold_reg)))
    else $error("lock stayed after disturbance");
  a_lock_no_detect: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_detect_en |=> !o_lock)
    else $error("lock shown with detection off");
endmodule : lock_tracker
`default_nettype wire

// ---- hw/clockgen_trim_status.sv ----
// trim, control and status registers of the clock generator
`timescale 1ns/1ps
`default_nettype none
module clockgen_trim_status (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_loop_locked,
  input  wire logic        i_loop_drift_out,
  input  wire logic        i_osc_init_done,
  input  wire logic        i_stop_entry,
  output logic      [7:0]  o_trim_coarse,
  output logic             o_trim_fine,
  output logic      [1:0]  o_clock_mode,
  output logic             o_ref_internal,
  output logic      [2:0]  o_ref_divider,
  output logic      [3:0]  o_vco_divider,
  output logic             o_fll_enable,
  output logic             o_pll_enable,
  output logic             o_lock_lost_irq
);
  logic [7:0]                     trim_reg, trim_next;
  logic                           fine_reg, fine_next;
  logic [clkgen_pkg::CTRL_W-1:0]  ctrl_reg, ctrl_next;
  logic                           lost_reg, lost_next;
  logic                           osc_reg, osc_next;
  logic                           irq_reg, irq_next;
  logic                           disturb_reg, disturb_next;
  logic                           fll_reg, fll_next;
  logic                           pll_reg, pll_next;
  logic                           wait_reg, wait_next;
  logic [31:0]                    rdata_reg, rdata_next;
  logic [3:0]                     sync_in, sync_out;
  logic [1:0]                     mode_st;
  logic                           loop_st, ref_st, lock_now, lost_event;
  logic                           wr_hit, rd_hit, ext_mode, int_mode, lowpwr_mode, pll_ext_mode;
  logic [clkgen_pkg::CTRL_W-1:0]  wr_ctrl;
  logic [1:0]                     cs_sel;
  logic [7:0]                     status_byte;
  logic                           trim_wr, status_wr, ctrl_wr, w1c_hit;

  // bus strobes: a write is taken on the edge where waitrequest is low, a read one edge earlier while it is still high
  assign wr_hit  = i_write && !wait_reg;
  assign rd_hit  = i_read && wait_reg;
  assign wr_ctrl = i_writedata[clkgen_pkg::CTRL_W-1:0];
  // decoded write strobes per register, shared by the checks below
  assign trim_wr   = wr_hit && i_address == clkgen_pkg::OFS_TRIM;
  assign status_wr = wr_hit && i_address == clkgen_pkg::OFS_STATUS;
  assign ctrl_wr   = wr_hit && i_address == clkgen_pkg::OFS_CTRL;
  assign w1c_hit   = status_wr && i_writedata[clkgen_pkg::LOST_BIT];

  // requested clock mode code, reserved select falls back to the loop
  always_comb begin
    cs_sel = ctrl_reg[clkgen_pkg::CS_LSB +: 2];
    if (cs_sel == clkgen_pkg::MODE_PLL) cs_sel = clkgen_pkg::MODE_LOOP;
    sync_in = {cs_sel == clkgen_pkg::MODE_LOOP && ctrl_reg[clkgen_pkg::LOOPSEL] ? clkgen_pkg::MODE_PLL : cs_sel,
               ctrl_reg[clkgen_pkg::REFSEL], ctrl_reg[clkgen_pkg::LOOPSEL]};
  end

  // status follows the selects only after the crossing delay
  status_sync #(.WIDTH(4)) u_sync (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_level     (sync_in),
    .i_reset_val (4'h0),
    .o_level     (sync_out)
  );
  assign mode_st = sync_out[3:2];
  assign ref_st  = sync_out[1];
  assign loop_st = sync_out[0];

  // operating mode decode from the synchronised status
  always_comb begin
    lowpwr_mode  = ctrl_reg[clkgen_pkg::LOWPWR] &&
                   (mode_st == clkgen_pkg::MODE_INT || mode_st == clkgen_pkg::MODE_EXT);
    int_mode     = ref_st;
    ext_mode     = !ref_st;
    pll_ext_mode = ext_mode && loop_st &&
                   (mode_st == clkgen_pkg::MODE_PLL || mode_st == clkgen_pkg::MODE_EXT) && !lowpwr_mode;
  end

  lock_tracker u_lock (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_detect_en  (fll_reg || pll_reg),
    .i_raw_lock   (i_loop_locked),
    .i_disturb    (disturb_reg || i_stop_entry || lowpwr_mode),
    .i_drift_out  (i_loop_drift_out),
    .o_lock       (lock_now),
    .o_lost_event (lost_event)
  );

  assign status_byte = {lost_reg, lock_now, loop_st, ref_st, mode_st, osc_reg, fine_reg};

  // register writes, sticky flags and derived controls
  always_comb begin
    trim_next    = trim_reg;
    fine_next    = fine_reg;
    ctrl_next    = ctrl_reg;
    disturb_next = 1'b0;
    if (wr_hit && i_address == clkgen_pkg::OFS_TRIM) begin
      trim_next = i_writedata[7:0];
      disturb_next = (trim_next != trim_reg) && int_mode && !lowpwr_mode &&
                     mode_st != clkgen_pkg::MODE_EXT;
    end
    if (wr_hit && i_address == clkgen_pkg::OFS_STATUS)
      fine_next = i_writedata[clkgen_pkg::FINE_BIT];
    if (wr_hit && i_address == clkgen_pkg::OFS_CTRL) begin
      ctrl_next = wr_ctrl;
      disturb_next = wr_ctrl[clkgen_pkg::REFSEL] != ctrl_reg[clkgen_pkg::REFSEL] ||
                     wr_ctrl[clkgen_pkg::LOOPSEL] != ctrl_reg[clkgen_pkg::LOOPSEL] ||
                     wr_ctrl[clkgen_pkg::REFDIV_LSB +: 3] != ctrl_reg[clkgen_pkg::REFDIV_LSB +: 3] ||
                     (pll_ext_mode &&
                      wr_ctrl[clkgen_pkg::VCODIV_LSB +: 4] != ctrl_reg[clkgen_pkg::VCODIV_LSB +: 4]);
    end
    // set wins over the write-one clear
    lost_next = lost_reg;
    if (wr_hit && i_address == clkgen_pkg::OFS_STATUS && i_writedata[clkgen_pkg::LOST_BIT])
      lost_next = 1'b0;
    if (lost_event) lost_next = 1'b1;
    irq_next = lost_reg && ctrl_reg[clkgen_pkg::IRQEN];
    // oscillator ready: clear cases first, set only when requested and in use
    osc_next = osc_reg;
    if (!ctrl_reg[clkgen_pkg::OSCREQ] || (int_mode && !ctrl_reg[clkgen_pkg::EXTEN]))
      osc_next = 1'b0;
    else if (i_osc_init_done && (ctrl_reg[clkgen_pkg::EXTEN] || ext_mode))
      osc_next = 1'b1;
    // unselected loop off; both off in low-power bypass
    pll_next = ctrl_reg[clkgen_pkg::LOOPSEL] && !lowpwr_mode;
    fll_next = !ctrl_reg[clkgen_pkg::LOOPSEL] && !lowpwr_mode;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      trim_reg    <= clkgen_pkg::TRIM_RESET;
      fine_reg    <= 1'b0;
      ctrl_reg    <= clkgen_pkg::CTRL_RESET;
      lost_reg    <= 1'b0;
      osc_reg     <= 1'b0;
      irq_reg     <= 1'b0;
      disturb_reg <= 1'b0;
      fll_reg     <= 1'b0;
      pll_reg     <= 1'b0;
    end else begin
      trim_reg    <= trim_next;
      fine_reg    <= fine_next;
      ctrl_reg    <= ctrl_next;
      lost_reg    <= lost_next;
      osc_reg     <= osc_next;
      irq_reg     <= irq_next;
      disturb_reg <= disturb_next;
      fll_reg     <= fll_next;
      pll_reg     <= pll_next;
    end
  end

  // bus handshake: one wait cycle, then a single low cycle carrying data
  always_comb begin
    wait_next  = !((i_read || i_write) && wait_reg);
    rdata_next = rdata_reg;
    if (rd_hit) begin
      case (i_address)
        clkgen_pkg::OFS_TRIM:   rdata_next = {24'h00_0000, trim_reg};
        clkgen_pkg::OFS_STATUS: rdata_next = {24'h00_0000, status_byte};
        clkgen_pkg::OFS_CTRL:   rdata_next = {16'h0000, ctrl_reg};
        default:                rdata_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_readdata      = rdata_reg;
  assign o_waitrequest   = wait_reg;
  assign o_trim_coarse   = trim_reg;
  assign o_trim_fine     = fine_reg;
  assign o_clock_mode    = ctrl_reg[clkgen_pkg::CS_LSB +: 2];
  assign o_ref_internal  = ctrl_reg[clkgen_pkg::REFSEL];
  assign o_ref_divider   = ctrl_reg[clkgen_pkg::REFDIV_LSB +: 3];
  assign o_vco_divider   = ctrl_reg[clkgen_pkg::VCODIV_LSB +: 4];
  assign o_fll_enable    = fll_reg;
  assign o_pll_enable    = pll_reg;
  assign o_lock_lost_irq = irq_reg;

  sequence s_status_w1c;
    w1c_hit;
  endsequence
  a_lost_w1c: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_status_w1c ##0 !lost_event |=> !lost_reg)
    else $error("lost flag not cleared by write one");
  a_lost_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    lost_reg && !w1c_hit |=> lost_reg)
    else $error("lost flag dropped without clear");
  a_lost_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    lost_event |=> lost_reg)
    else $error("lost flag missed an event");
  a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ##1 o_lock_lost_irq == ($past(lost_reg) && $past(ctrl_reg[clkgen_pkg::IRQEN])))
    else $error("interrupt not gated by enable");
  a_loop_status: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ##2 loop_st == $past(ctrl_reg[clkgen_pkg::LOOPSEL], 2))
    else $error("loop status not two cycles behind select");
  a_ref_status: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $changed(ctrl_reg[clkgen_pkg::REFSEL]) |-> ref_st != ctrl_reg[clkgen_pkg::REFSEL] ##2
      ref_st == $past(ctrl_reg[clkgen_pkg::REFSEL], 2))
    else $error("reference status updated too early or late");
  a_loop_excl: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !(o_fll_enable && o_pll_enable))
    else $error("both loops enabled");
  a_osc_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ctrl_reg[clkgen_pkg::OSCREQ] |=> !osc_reg)
    else $error("osc ready stayed without request");
  a_fine_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_hit && i_address == clkgen_pkg::OFS_STATUS |=> fine_reg == $past(i_writedata[clkgen_pkg::FINE_BIT]))
    else $error("fine trim write lost");
  a_bus_answer: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_read || i_write) && wait_reg |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle");

  // a reference or loop select or reference divider change must show as unlock two edges on
  sequence s_sel_change;
    ctrl_wr && (wr_ctrl[clkgen_pkg::REFSEL +: 2] != ctrl_reg[clkgen_pkg::REFSEL +: 2] ||
                wr_ctrl[clkgen_pkg::REFDIV_LSB +: 3] != ctrl_reg[clkgen_pkg::REFDIV_LSB +: 3]);
  endsequence
  a_sel_disturb: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_sel_change |-> ##2 !lock_now)
    else $error("lock kept after select change");
  a_stop_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_stop_entry |=> !lock_now)
    else $error("lock kept at stop entry");
  a_lowpwr_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    lowpwr_mode |=> !lock_now)
    else $error("lock kept in low-power bypass");
  a_loop_lowpwr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    lowpwr_mode |=> !o_fll_enable && !o_pll_enable)
    else $error("loop left running in low-power bypass");
  a_irq_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !lost_reg |=> !o_lock_lost_irq)
    else $error("interrupt without lost flag");
  a_irq_masked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ctrl_reg[clkgen_pkg::IRQEN] |=> !o_lock_lost_irq)
    else $error("interrupt raised while disabled");
  // registers only move on their own write strobe
  a_trim_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trim_wr |=> o_trim_coarse == $past(i_writedata[7:0]))
    else $error("coarse trim write lost");
  a_trim_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !trim_wr |=> $stable(o_trim_coarse))
    else $error("coarse trim moved without write");
  a_fine_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !status_wr |=> $stable(o_trim_fine))
    else $error("fine trim moved without write");
  a_ctrl_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ctrl_wr |=> $stable(ctrl_reg))
    else $error("control moved without write");
  // clock mode status lags the source select by the two crossing stages
  a_mode_int: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(ctrl_reg[clkgen_pkg::CS_LSB +: 2], 2) == clkgen_pkg::MODE_INT |-> mode_st == clkgen_pkg::MODE_INT)
    else $error("internal mode status wrong");
  a_mode_ext: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(ctrl_reg[clkgen_pkg::CS_LSB +: 2], 2) == clkgen_pkg::MODE_EXT |-> mode_st == clkgen_pkg::MODE_EXT)
    else $error("external mode status wrong");
  a_mode_pll: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ($past(ctrl_reg[clkgen_pkg::CS_LSB +: 2], 2) == clkgen_pkg::MODE_LOOP ||
     $past(ctrl_reg[clkgen_pkg::CS_LSB +: 2], 2) == clkgen_pkg::MODE_PLL) &&
    $past(ctrl_reg[clkgen_pkg::LOOPSEL], 2) |-> mode_st == clkgen_pkg::MODE_PLL)
    else $error("pll mode status wrong");
  a_mode_fll: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ($past(ctrl_reg[clkgen_pkg::CS_LSB +: 2], 2) == clkgen_pkg::MODE_LOOP ||
     $past(ctrl_reg[clkgen_pkg::CS_LSB +: 2], 2) == clkgen_pkg::MODE_PLL) &&
    !$past(ctrl_reg[clkgen_pkg::LOOPSEL], 2) |-> mode_st == clkgen_pkg::MODE_LOOP)
    else $error("fll mode status wrong");
  // oscillator ready only moves on its own set and clear cases
  a_osc_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ctrl_reg[clkgen_pkg::OSCREQ] && !(int_mode && !ctrl_reg[clkgen_pkg::EXTEN]) && i_osc_init_done &&
    (ctrl_reg[clkgen_pkg::EXTEN] || ext_mode) |=> osc_reg)
    else $error("osc ready not set");
  a_osc_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    osc_reg && ctrl_reg[clkgen_pkg::OSCREQ] && !(int_mode && !ctrl_reg[clkgen_pkg::EXTEN]) |=> osc_reg)
    else $error("osc ready dropped without cause");
  a_osc_int_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    int_mode && !ctrl_reg[clkgen_pkg::EXTEN] |=> !osc_reg)
    else $error("osc ready kept in internal mode");
endmodule : clockgen_trim_status
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the clock generator trim and status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_sys_clk, i_rst_n, i_read, i_write;
  logic [3:0]  i_address;
  logic [31:0] i_writedata, o_readdata, rd;
  logic        o_waitrequest, o_trim_fine, o_ref_internal, o_fll_enable, o_pll_enable, o_lock_lost_irq;
  logic        i_loop_locked, i_loop_drift_out, i_osc_init_done, i_stop_entry;
  logic [7:0]  o_trim_coarse;
  logic [1:0]  o_clock_mode;
  logic [2:0]  o_ref_divider;
  logic [3:0]  o_vco_divider;
  int          miscompares, checks_done;
  int          cycles = 0;

  clockgen_trim_status u_clockgen_trim_status (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_loop_locked(i_loop_locked), .i_loop_drift_out(i_loop_drift_out), .i_osc_init_done(i_osc_init_done),
    .i_stop_entry(i_stop_entry), .o_trim_coarse(o_trim_coarse), .o_trim_fine(o_trim_fine),
    .o_clock_mode(o_clock_mode), .o_ref_internal(o_ref_internal), .o_ref_divider(o_ref_divider),
    .o_vco_divider(o_vco_divider), .o_fll_enable(o_fll_enable), .o_pll_enable(o_pll_enable),
    .o_lock_lost_irq(o_lock_lost_irq)
  );

  // 25 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // avalon request held until waitrequest is sampled low
  task automatic bus_cycle(input logic is_write, input logic [3:0] addr, input logic [31:0] data);
    int n;
    @(posedge i_sys_clk);
    i_address   <= addr;
    i_writedata <= data;
    i_write     <= is_write;
    i_read      <= ~is_write;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n = n + 1;
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    // only the hang guard ends a wait; the answer is due on the second edge after the request
    check(n, 32'h0000_0002, "bus answer latency");
    i_write <= 1'b0;
    i_read  <= 1'b0;
  endtask : bus_cycle

  task automatic read_check(input logic [3:0] addr, input logic [31:0] mask, input logic [31:0] exp,
                            input string msg);
    bus_cycle(1'b0, addr, 32'h0000_0000);
    check(rd & mask, exp, msg);
  endtask : read_check

  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : idle

  // relock needs the raw lock to fall and rise again
  task automatic relock();
    i_loop_locked <= 1'b0;
    idle(3);
    i_loop_locked <= 1'b1;
    idle(4);
  endtask : relock

  task automatic test_reset();
    read_check(clkgen_pkg::OFS_TRIM, 32'hFFFF_FFFF, {24'h0, clkgen_pkg::TRIM_RESET}, "trim reset");
    read_check(clkgen_pkg::OFS_CTRL, 32'hFFFF_FFFF, {16'h0, clkgen_pkg::CTRL_RESET}, "ctrl reset");
    read_check(clkgen_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0010, "status reset");
    read_check(4'hC, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask : test_reset

  task automatic test_trim();
    bus_cycle(1'b1, clkgen_pkg::OFS_TRIM, 32'h0000_005A);
    idle(1);
    check({24'h0, o_trim_coarse}, 32'h0000_005A, "coarse trim out");
    read_check(clkgen_pkg::OFS_TRIM, 32'hFFFF_FFFF, 32'h0000_005A, "trim readback");
    bus_cycle(1'b1, 4'hC, 32'h0000_00FF);
    read_check(clkgen_pkg::OFS_TRIM, 32'hFFFF_FFFF, 32'h0000_005A, "unmapped write");
    // ones in every status bit: only the fine trim may take it
    bus_cycle(1'b1, clkgen_pkg::OFS_STATUS, 32'h0000_00FF);
    idle(1);
    check({31'h0, o_trim_fine}, 32'h0000_0001, "fine trim out");
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_00FF, 32'h0000_0011, "status read-only");
    bus_cycle(1'b1, clkgen_pkg::OFS_STATUS, 32'h0000_0000);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0000, "fine trim clear");
    $display("test trim done");
  endtask : test_trim

  task automatic test_lost();
    i_loop_locked <= 1'b1;
    idle(4);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_00C0, 32'h0000_0040, "lock shown");
    i_loop_drift_out <= 1'b1;
    idle(1);
    i_loop_drift_out <= 1'b0;
    idle(3);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0080, 32'h0000_0080, "lost flag set");
    check({31'h0, o_lock_lost_irq}, 32'h0000_0000, "irq masked");
    bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, 32'h0000_4104);
    idle(3);
    check({31'h0, o_lock_lost_irq}, 32'h0000_0001, "irq raised");
    bus_cycle(1'b1, clkgen_pkg::OFS_STATUS, 32'h0000_0000);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0080, 32'h0000_0080, "zero keeps flag");
    bus_cycle(1'b1, clkgen_pkg::OFS_STATUS, 32'h0000_0080);
    idle(3);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0080, 32'h0000_0000, "one clears flag");
    check({31'h0, o_lock_lost_irq}, 32'h0000_0000, "irq dropped");
    $display("test lost done");
  endtask : test_lost

  task automatic test_disturb();
    relock();
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0040, "relocked");
    bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, 32'h0000_0114);
    idle(4);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0000, "divider change");
    check({25'h0, o_vco_divider, o_ref_divider}, {25'h0, 4'h1, 3'h1}, "divider outputs");
    relock();
    bus_cycle(1'b1, clkgen_pkg::OFS_TRIM, 32'h0000_0033);
    idle(4);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0000, "trim change internal");
    relock();
    i_stop_entry <= 1'b1;
    idle(1);
    i_stop_entry <= 1'b0;
    idle(4);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0000, "stop entry");
    relock();
    bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, 32'h0000_8115);
    idle(4);
    relock();
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0000, "low-power held");
    bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, 32'h0000_0114);
    idle(4);
    relock();
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0040, "low-power left");
    // pll external mode: a vco divider change must drop lock
    bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, 32'h0000_0108);
    idle(4);
    relock();
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0040, "pll locked");
    bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, 32'h0000_0208);
    idle(4);
    read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0040, 32'h0000_0000, "vco change external");
    $display("test disturb done");
  endtask : test_disturb

  task automatic test_modes();
    logic [15:0] ctrl [5] = '{16'h0104, 16'h0105, 16'h0102, 16'h0108, 16'h0107};
    logic [3:0]  stat [5] = '{4'h4, 4'h5, 4'h2, 4'hB, 4'h4};
    for (int k = 0; k < 5; k++) begin
      bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, {16'h0, ctrl[k]});
      idle(3);
      read_check(clkgen_pkg::OFS_STATUS, 32'h0000_003C, {26'h0, stat[k], 2'h0}, "mode status");
      check({30'h0, o_pll_enable, o_fll_enable}, {30'h0, ctrl[k][3], ~ctrl[k][3]}, "loop enables");
      check({29'h0, o_ref_internal, o_clock_mode}, {29'h0, ctrl[k][2:0]}, "select outputs");
    end
    $display("test modes done");
  endtask : test_modes

  task automatic test_osc();
    // last entry sets ready through the external reference mode alone
    logic [15:0] ctrl [5] = '{16'h3104, 16'h1104, 16'h3104, 16'h2104, 16'h1102};
    i_osc_init_done <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      bus_cycle(1'b1, clkgen_pkg::OFS_CTRL, {16'h0, ctrl[k]});
      idle(3);
      read_check(clkgen_pkg::OFS_STATUS, 32'h0000_0002, {30'h0, ~k[0], 1'b0}, "osc ready");
    end
    $display("test osc done");
  endtask : test_osc

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    miscompares = 0;
    checks_done = 0;
    i_rst_n = 1'b0;
    {i_read, i_write, i_address, i_writedata} = '0;
    {i_loop_locked, i_loop_drift_out, i_osc_init_done, i_stop_entry} = '0;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    idle(3);
    test_reset();
    test_trim();
    test_lost();
    test_disturb();
    test_modes();
    test_osc();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
